// >>> bench/pcs_panel_crc_asserts.sv
`default_nettype none
module pcs_panel_crc_asserts #(
  parameter int PIX_W = 18,
  parameter int LANE_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic frame_start,
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_upper,
  input wire logic [PIX_W-1:0] pix_lower,
  input wire logic panel_shift_clock,
  input wire logic [LANE_W-1:0] upper_panel_data,
  input wire logic [LANE_W-1:0] lower_panel_data,
  input wire logic [5:0] frame_index
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] type_q;
  logic [1:0] ctrl_q;
  wire acc = psel && penable;
  wire rd_cfg = acc && !pwrite && paddr == pcs_pkg::PCS_OFF_PANEL_CFG;
  wire rd_sig = acc && !pwrite && paddr == pcs_pkg::PCS_OFF_SIG;
  wire mapped = paddr == pcs_pkg::PCS_OFF_PANEL_CFG || paddr == pcs_pkg::PCS_OFF_SIG;
  wire tft = type_q == pcs_pkg::PCS_PT_TFT;
  // Shadow of the config bits, so lane checks know the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_q <= 3'h0;
      ctrl_q <= 2'h0;
    end else if (acc && pwrite && paddr == pcs_pkg::PCS_OFF_PANEL_CFG) begin
      type_q <= pwdata[18:16];
    end else if (acc && pwrite && paddr == pcs_pkg::PCS_OFF_SIG) begin
      ctrl_q <= pwdata[1:0];
    end
  end
  ready_high_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  cfg_read_a: assert property (rd_cfg |-> prdata == {13'h0, type_q, 16'h0})
    else $error("panel config readback wrong");
  ctrl_read_a: assert property (rd_sig |-> prdata[1:0] == ctrl_q)
    else $error("control bits readback wrong");
  fidx_step_a: assert property (frame_start |=> frame_index == 6'($past(frame_index) + 6'h01))
    else $error("frame index did not step");
  fidx_hold_a: assert property (!frame_start |=> $stable(frame_index))
    else $error("frame index moved");
  shift_cause_a: assert property (panel_shift_clock |-> $past(pix_valid))
    else $error("shift pulse without pixel");
  tft_pace_a: assert property (tft && pix_valid && !frame_start |=> panel_shift_clock)
    else $error("pass-through missed a word");
  stn_pulse_a: assert property (!tft && panel_shift_clock |=> !panel_shift_clock)
    else $error("packed mode pulse too long");
  zero_pins_a: assert property (panel_shift_clock && tft |-> upper_panel_data[1:0] == 2'h0
    && upper_panel_data[9:8] == 2'h0 && lower_panel_data[5:4] == 2'h0)
    else $error("unused pass-through pins not zero");
  single_scan_passive_panel_lower_a: assert property (panel_shift_clock && type_q == pcs_pkg::PCS_PT_SSTN8
    |-> lower_panel_data == 12'h000) else $error("single-scan lower lanes not zero");
endmodule : pcs_panel_crc_asserts
bind pcs_panel_crc pcs_panel_crc_asserts #(.PIX_W(PIX_W), .LANE_W(LANE_W)) chk_i (.*);
`default_nettype wire

// >>> bench/test_pcs_panel_crc.sv
`default_nettype none
module test_pcs_panel_crc;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic frame_start = 0, pix_valid = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [17:0] pix_upper = 18'h0, pix_lower = 18'h0;
  wire pready, pslverr, panel_shift_clock;
  wire [31:0] prdata;
  wire [11:0] upd, lpd;
  wire [5:0] frame_index;
  int fails = 0, check_count = 0;
  logic [23:0] crc, s1, s_tft, s_d24, s_d16;
  logic [5:0] fidx = 6'h00, i1, i2;
  pcs_panel_crc dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .frame_start(frame_start), .pix_valid(pix_valid),
    .pix_upper(pix_upper), .pix_lower(pix_lower), .panel_shift_clock(panel_shift_clock),
    .upper_panel_data(upd), .lower_panel_data(lpd), .frame_index(frame_index));
  always #10 pclk = ~pclk;
  task end_of_test;
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Waits up to 50 cycles for pready; at that limit it counts a failure and ends the test
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_of_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task sig_is(input string n, input logic [23:0] s, input logic [5:0] i, input logic [1:0] c);
    apb(1'b0, pcs_pkg::PCS_OFF_SIG, 32'h00000000);
    chk(n, {s, i, c}, rd);
  endtask : sig_is
  function automatic logic [23:0] crcw(input logic [23:0] s, input logic [23:0] w);
    logic [23:0] c;
    c = s;
    for (int i = 23; i >= 0; i--) begin
      if (c[23] ^ w[i]) begin
        c = {c[22:0], 1'b0} ^ pcs_pkg::PCS_CRC_POLY;
      end else begin
        c = {c[22:0], 1'b0};
      end
    end
    return c;
  endfunction : crcw
  // Lane order of the narrow modes, oldest bit first
  task automatic frame(input logic [2:0] m, input int np);
    logic [23:0] w;
    logic [17:0] u;
    logic [15:0] ub;
    logic [15:0] lb;
    logic [15:0] ob;
    logic [15:0] oc;
    int nb;
    int ul[8] = '{13, 12, 11, 10, 7, 6, 5, 4};
    int ll[8] = '{23, 22, 21, 20, 19, 18, 15, 14};
    w = 24'h000000;
    ub = 16'h0000;
    lb = 16'h0000;
    nb = 0;
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    fidx++;
    crc = pcs_pkg::PCS_CRC_SEED;
    for (int k = 0; k < np; k++) begin
      u = 18'(k * 18'h2A5B + 18'h1357);
      pix_valid <= 1'b1;
      pix_upper <= u;
      pix_lower <= ~u;
      ub = {ub[12:0], u[17], u[11], u[5]};
      lb = {lb[12:0], ~u[17], ~u[11], ~u[5]};
      nb = nb + 3;
      if (m == pcs_pkg::PCS_PT_TFT) begin
        w = {u[17:12], 2'h0, u[11:6], 2'h0, u[5:0], 2'h0};
        crc = crcw(crc, w);
      end else if (m == pcs_pkg::PCS_PT_DSTN24 && nb == 12) begin
        w = {lb[11:0], ub[11:0]};
        nb = 0;
        crc = crcw(crc, w);
      end else if (m != pcs_pkg::PCS_PT_DSTN24 && nb >= 8) begin
        nb = nb - 8;
        ob = ub >> nb;
        oc = lb >> nb;
        w = 24'h000000;
        for (int j = 0; j < 8; j++) begin
          if (m == pcs_pkg::PCS_PT_DSTN16 || m == pcs_pkg::PCS_PT_SSTN8) begin
            w[ul[j]] = ob[7 - j];
          end
          if (m == pcs_pkg::PCS_PT_DSTN16) begin
            w[ll[j]] = oc[7 - j];
          end
        end
        crc = crcw(crc, w);
      end
      @(posedge pclk);
    end
    pix_valid <= 1'b0;
    @(negedge pclk);
    chk("frame index", {26'h0, fidx}, {26'h0, frame_index});
    if (np > 0) begin
      chk("panel word", {8'h00, w}, {8'h00, lpd, upd});
    end
  endtask : frame
  task t_regs;
    sig_is("sig reset", 24'h000000, 6'h00, 2'h0);
    chk("mapped err", 32'h0, {31'h0, err});
    apb(1'b0, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00000000);
    chk("cfg reset", 32'h0, rd);
    apb(1'b1, 12'h400, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h400, 32'h00000000);
    chk("unmapped read err", 32'h1, {31'h0, err});
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, pcs_pkg::PCS_OFF_PANEL_CFG, 32'hFFFAFFFF);
    apb(1'b0, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00000000);
    chk("cfg stored bits", 32'h00020000, rd);
    apb(1'b1, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00000000);
  endtask : t_regs
  task t_free_run;
    apb(1'b1, pcs_pkg::PCS_OFF_SIG, 32'h00000003);
    frame(pcs_pkg::PCS_PT_TFT, 16);
    s1 = crc;
    i1 = fidx;
    frame(pcs_pkg::PCS_PT_TFT, 12);
    sig_is("free run first sig", s1, i1, 2'h3);
    s_tft = crc;
    i2 = fidx;
    apb(1'b1, pcs_pkg::PCS_OFF_SIG, 32'h00000001);
    frame(pcs_pkg::PCS_PT_TFT, 8);
    sig_is("last free run sig", s_tft, i2, 2'h1);
    frame(pcs_pkg::PCS_PT_TFT, 8);
    apb(1'b1, pcs_pkg::PCS_OFF_SIG, 32'hFFFFFF01);
    sig_is("sig held read only", s_tft, i2, 2'h1);
    // Captured frame cut short by disable leaves the old signature
    apb(1'b1, pcs_pkg::PCS_OFF_SIG, 32'h00000003);
    frame(pcs_pkg::PCS_PT_TFT, 8);
    apb(1'b1, pcs_pkg::PCS_OFF_SIG, 32'h00000000);
    frame(pcs_pkg::PCS_PT_TFT, 8);
    sig_is("disabled sig held", s_tft, i2, 2'h0);
  endtask : t_free_run
  task t_dual_scan;
    apb(1'b1, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00020000);
    apb(1'b1, pcs_pkg::PCS_OFF_SIG, 32'h00000003);
    frame(pcs_pkg::PCS_PT_DSTN24, 12);
    s_d24 = crc;
    i1 = fidx;
    apb(1'b1, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00010000);
    frame(pcs_pkg::PCS_PT_DSTN16, 12);
    sig_is("wide dual scan sig", s_d24, i1, 2'h3);
    s_d16 = crc;
    i2 = fidx;
    apb(1'b1, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00030000);
    frame(pcs_pkg::PCS_PT_SSTN8, 8);
    sig_is("narrow dual scan sig", s_d16, i2, 2'h3);
    chk("sig per panel type", 32'h1, {31'h0, s_d24 != s_d16 && s_d16 != s_tft});
    apb(1'b1, pcs_pkg::PCS_OFF_PANEL_CFG, 32'h00040000);
    frame(3'h4, 8);
  endtask : t_dual_scan
  task t_wrap;
    i1 = fidx;
    repeat (64) frame(pcs_pkg::PCS_PT_TFT, 0);
    chk("frame index wrap", {26'h0, i1}, {26'h0, frame_index});
  endtask : t_wrap
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_free_run();
    t_dual_scan();
    t_wrap();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    end_of_test();
  end
endmodule : test_pcs_panel_crc
`default_nettype wire

// >>> design/pcs_crc_engine.sv
`default_nettype none
module pcs_crc_engine #(
  parameter int W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic seed_load,
  input wire logic data_valid,
  input wire logic [W-1:0] data,
  output logic [W-1:0] state_q
);

  logic [W-1:0] state_d;

  // One full word per call, oldest bit (MSB) first
  function automatic logic [W-1:0] crc_word(input logic [W-1:0] s_in,
                                            input logic [W-1:0] d);
    logic [W-1:0] s;
    logic fb;
    s = s_in;
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb = s[W-1] ^ d[i];
      s = {s[W-2:0], 1'b0};
      if (fb) begin
        s = s ^ pcs_pkg::PCS_CRC_POLY;
      end
    end
    return s;
  endfunction : crc_word

  always_comb begin
    state_d = seed_load ? pcs_pkg::PCS_CRC_SEED : state_q;
    if (data_valid) begin
      state_d = crc_word(state_d, data);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pcs_pkg::PCS_CRC_SEED;
    end else begin
      state_q <= state_d;
    end
  end

endmodule : pcs_crc_engine
`default_nettype wire

// >>> design/pcs_panel_crc.sv
// Design decision made here: the APB slave port.
`default_nettype none
module pcs_panel_crc #(
  parameter int PIX_W = 18,
  parameter int LANE_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_upper,
  input wire logic [PIX_W-1:0] pix_lower,
  output logic panel_shift_clock,
  output logic [LANE_W-1:0] upper_panel_data,
  output logic [LANE_W-1:0] lower_panel_data,
  output logic [5:0] frame_index
);

  localparam int WORD_W = 2 * LANE_W;
  localparam int BUF_W = 16;
  localparam int CW = pcs_pkg::PCS_PIX_BITS;

  // Register state
  logic [2:0] panel_type_q;
  logic sig_en_q;
  logic free_run_q;
  logic [23:0] sig_q;
  logic [5:0] sig_fidx_q;

  // Frame and capture state
  logic [5:0] fidx_q;
  logic frame_q;
  logic fr_sampled_q;
  logic capture_q;

  // Gather state
  logic [BUF_W-1:0] ubuf_q;
  logic [BUF_W-1:0] lbuf_q;
  logic [4:0] cnt_q;
  logic [WORD_W-1:0] word_q;
  logic shift_q;

  // Combinational helpers
  logic setup;
  logic wr_en;
  logic hit_cfg;
  logic hit_sig;
  logic [2:0] ucol;
  logic [2:0] lcol;
  logic [BUF_W-1:0] ubuf_d;
  logic [BUF_W-1:0] lbuf_d;
  logic [4:0] cnt_sum;
  logic [4:0] need;
  logic emit;
  logic [4:0] sh;
  logic [11:0] ubits;
  logic [11:0] lbits;
  logic [WORD_W-1:0] word_d;
  logic [23:0] crc_state;
  logic crc_seed;
  logic crc_valid;

  // APB decode
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign hit_cfg = (paddr == pcs_pkg::PCS_OFF_PANEL_CFG);
  assign hit_sig = (paddr == pcs_pkg::PCS_OFF_SIG);
  // Zero-wait slave, so an unmapped access errors in its only access cycle
  assign pslverr = psel & penable & ~(hit_cfg | hit_sig);

  // Oldest N bits of the gather buffer, shifted down by sh
  function automatic logic [11:0] take_bits(input logic [BUF_W-1:0] b,
                                            input logic [4:0] s);
    logic [BUF_W-1:0] t;
    t = b >> s;
    return t[11:0];
  endfunction : take_bits

  // One panel color bit per primary for passive panels
  function automatic logic [2:0] stn_color(input logic [PIX_W-1:0] p);
    return {p[PIX_W-1], p[(2*PIX_W/3)-1], p[(PIX_W/3)-1]};
  endfunction : stn_color

  // Narrow modes use eight lanes per group; rest stays zero
  function automatic logic [WORD_W-1:0] narrow_upper(input logic [7:0] b);
    return {10'h000, b[7:4], 2'h0, b[3:0], 4'h0};
  endfunction : narrow_upper

  function automatic logic [WORD_W-1:0] narrow_lower(input logic [7:0] b);
    return {b[7:2], 2'h0, b[1:0], 14'h0000};
  endfunction : narrow_lower

  // Panel configuration register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_type_q <= pcs_pkg::PCS_PTYPE_RST;
    end else if (wr_en && hit_cfg) begin
      panel_type_q <= pwdata[pcs_pkg::PCS_PTYPE_LSB +: pcs_pkg::PCS_PTYPE_W];
    end
  end

  // Signature control bits; upper fields ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_en_q <= pcs_pkg::PCS_SIG_CTRL_RST[pcs_pkg::PCS_EN_BIT];
      free_run_q <= pcs_pkg::PCS_SIG_CTRL_RST[pcs_pkg::PCS_FR_BIT];
    end else if (wr_en && hit_sig) begin
      sig_en_q <= pwdata[pcs_pkg::PCS_EN_BIT];
      free_run_q <= pwdata[pcs_pkg::PCS_FR_BIT];
    end
  end

  // Read data registered in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      if (hit_cfg) begin
        prdata <= {13'h0000, panel_type_q, 16'h0000};
      end else if (hit_sig) begin
        prdata <= {sig_q, sig_fidx_q, free_run_q, sig_en_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Frame index for the shading pipeline, wraps at 64
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fidx_q <= pcs_pkg::PCS_FIDX_RST;
    end else if (frame_start) begin
      fidx_q <= fidx_q + 6'h01;
    end
  end

  assign frame_index = fidx_q;

  // Control sampled on the frame's first cycle, applied one cycle later
  // to line up with the registered panel word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= 1'b0;
      fr_sampled_q <= 1'b0;
    end else begin
      frame_q <= frame_start;
      if (frame_start) begin
        fr_sampled_q <= free_run_q & sig_en_q;
      end
    end
  end

  // Capture window: one frame per sampled free-run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= 1'b0;
    end else if (!sig_en_q) begin
      capture_q <= 1'b0;
    end else if (frame_q) begin
      // Stays set while free-run holds; a clear ends it here
      capture_q <= fr_sampled_q;
    end
  end

  // Latch finished signature and its frame index at the boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q <= pcs_pkg::PCS_SIG_RST;
      sig_fidx_q <= pcs_pkg::PCS_FIDX_RST;
    end else if (frame_q && capture_q && sig_en_q) begin
      sig_q <= crc_state;
      sig_fidx_q <= fidx_q - 6'h01;
    end
  end

  // Gathering panel bits into shift transfers
  always_comb begin
    ucol = stn_color(pix_upper);
    lcol = stn_color(pix_lower);
    ubuf_d = {ubuf_q[BUF_W-CW-1:0], ucol};
    lbuf_d = {lbuf_q[BUF_W-CW-1:0], lcol};
    cnt_sum = cnt_q + pcs_pkg::PCS_PIX_BITS;
    need = (panel_type_q == pcs_pkg::PCS_PT_DSTN24) ? pcs_pkg::PCS_WIDE_BITS :
                                                     pcs_pkg::PCS_NARROW_BITS;
    emit = 1'b0;
    sh = 5'h00;
    word_d = '0;
    if (pix_valid) begin
      if (panel_type_q == pcs_pkg::PCS_PT_TFT) begin
        emit = 1'b1;
      end else begin
        emit = (cnt_sum >= need);
        sh = cnt_sum - need;
      end
    end
    ubits = take_bits(ubuf_d, sh);
    lbits = take_bits(lbuf_d, sh);
    unique case (panel_type_q)
      pcs_pkg::PCS_PT_TFT: begin
        // One pixel per shift, two unused low pins per color
        word_d = {pix_upper[17:12], 2'h0, pix_upper[11:6], 2'h0,
                  pix_upper[5:0], 2'h0};
      end
      pcs_pkg::PCS_PT_DSTN24: begin
        word_d = {lbits, ubits};
      end
      pcs_pkg::PCS_PT_DSTN16: begin
        word_d = narrow_upper(ubits[7:0]) | narrow_lower(lbits[7:0]);
      end
      pcs_pkg::PCS_PT_SSTN8: begin
        word_d = narrow_upper(ubits[7:0]);
      end
      default: begin
        // Reserved codes leave every pin low
        word_d = '0;
      end
    endcase
  end

  // Gather buffer and bit count; a frame restarts the packing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ubuf_q <= '0;
      lbuf_q <= '0;
      cnt_q <= 5'h00;
    end else if (frame_start) begin
      ubuf_q <= '0;
      lbuf_q <= '0;
      cnt_q <= 5'h00;
    end else if (pix_valid && panel_type_q != pcs_pkg::PCS_PT_TFT) begin
      ubuf_q <= ubuf_d;
      lbuf_q <= lbuf_d;
      cnt_q <= emit ? sh : cnt_sum;
    end
  end

  // Registered panel word and shift strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= '0;
      shift_q <= 1'b0;
    end else begin
      shift_q <= emit & ~frame_start;
      if (emit && !frame_start) begin
        word_q <= word_d;
      end
    end
  end

  assign panel_shift_clock = shift_q;
  assign upper_panel_data = word_q[LANE_W-1:0];
  assign lower_panel_data = word_q[WORD_W-1:LANE_W];

  // Seed on each frame boundary; accumulate only while capturing.
  // The same-cycle word belongs to the new frame, after the seed.
  assign crc_seed = frame_q;
  assign crc_valid = shift_q & sig_en_q &
                     (frame_q ? fr_sampled_q : capture_q);

  pcs_crc_engine #(
    .W(24)
  ) u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .seed_load(crc_seed),
    .data_valid(crc_valid),
    .data(word_q),
    .state_q(crc_state)
  );

endmodule : pcs_panel_crc
`default_nettype wire

// >>> include/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
  // Register byte offsets
  localparam logic [11:0] PCS_OFF_PANEL_CFG = 12'h404;
  localparam logic [11:0] PCS_OFF_SIG = 12'h42C;
  localparam int PCS_ADDR_W = 12;
  // Panel configuration fields
  localparam int PCS_PTYPE_LSB = 16;
  localparam int PCS_PTYPE_W = 3;
  localparam logic [2:0] PCS_PTYPE_RST = 3'h0;
  localparam logic [2:0] PCS_PT_TFT = 3'h0;
  localparam logic [2:0] PCS_PT_DSTN16 = 3'h1;
  localparam logic [2:0] PCS_PT_DSTN24 = 3'h2;
  localparam logic [2:0] PCS_PT_SSTN8 = 3'h3;
  // Signature register fields
  localparam int PCS_SIG_LSB = 8;
  localparam int PCS_SIG_W = 24;
  localparam int PCS_FIDX_LSB = 2;
  localparam int PCS_FIDX_W = 6;
  localparam int PCS_FR_BIT = 1;
  localparam int PCS_EN_BIT = 0;
  localparam logic [1:0] PCS_SIG_CTRL_RST = 2'h0;
  localparam logic [23:0] PCS_SIG_RST = 24'h000000;
  localparam logic [5:0] PCS_FIDX_RST = 6'h00;
  // CRC: 1 + x^3 + x^4 + x^24, x^24 implicit
  localparam logic [23:0] PCS_CRC_POLY = 24'h000019;
  localparam logic [23:0] PCS_CRC_SEED = 24'hFFFFFF;
  // Panel bits per shift transfer, and per pixel (PCS_PIX_BITS)
  localparam logic [4:0] PCS_NARROW_BITS = 5'h08;
  localparam logic [4:0] PCS_WIDE_BITS = 5'h0C;
  localparam logic [4:0] PCS_PIX_BITS = 5'h03;
endpackage : pcs_pkg
`default_nettype wire
